/* logic/xcvr_pkg.sv */
// Constants shared by the quad bus transceiver and its bit slice.
// Assumes all pin-side inputs arrive asynchronously to ref_clk.
package xcvr_pkg;
  localparam int unsigned LANES = 4;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] COUNT_OFS = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_CAPTURE_BIT = 0;

  // Status register fields
  localparam int unsigned ST_DRV_LSB = 0;
  localparam int unsigned ST_LATCH_LSB = 4;
  localparam int unsigned ST_BUS_LSB = 8;
  localparam int unsigned ST_DRIVE_ON_BIT = 12;
  localparam int unsigned ST_RX_ON_BIT = 13;
  localparam int unsigned ST_SEL_BIT = 14;
  localparam int unsigned ST_HOLD_BIT = 15;

  // Layout of the synchroniser vector
  localparam int unsigned SYNC_W = 17;
  localparam int unsigned SY_CLK = 16;
  localparam int unsigned SY_SEL = 15;
  localparam int unsigned SY_FIRST_LSB = 11;
  localparam int unsigned SY_SECOND_LSB = 7;
  localparam int unsigned SY_BE_N = 6;
  localparam int unsigned SY_HOLD = 5;
  localparam int unsigned SY_OE_N = 4;
  localparam int unsigned SY_BUS_LSB = 0;

  // Values after reset: both active-low enables read as disabled
  localparam logic [16:0] SYNC_RST = 17'h00050;
  localparam logic DRV_BIT_RST = 1'h0;
  localparam logic LATCH_BIT_RST = 1'h0;
  localparam logic CLK_PREV_RST = 1'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [31:0] READ_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

/* logic/bit_slice.sv */
// One bit position: word multiplexer, driver register bit and receive latch bit.
// Assumes capture is a one-cycle pulse and all inputs are already on ref_clk.
`timescale 1ns/10ps
module bit_slice (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Driver side
  input wire logic first_bit,
  input wire logic second_bit,
  input wire logic word_select,
  input wire logic capture,
  // Receiver side
  input wire logic bus_bit,
  input wire logic hold,
  // State
  output logic drv_q,
  output logic latch_q
);
  logic drv_r;
  logic drv_nxt;
  logic latch_r;
  logic latch_nxt;
  logic mux_out;

  always_comb begin
    mux_out = word_select ? second_bit : first_bit;
    drv_nxt = drv_r;
    if (capture) begin
      drv_nxt = mux_out;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drv_r <= xcvr_pkg::DRV_BIT_RST;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  // Open latch follows the inverted bus level, closed latch keeps its value
  always_comb begin
    latch_nxt = latch_r;
    if (!hold) begin
      latch_nxt = ~bus_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= xcvr_pkg::LATCH_BIT_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign drv_q = drv_r;
  assign latch_q = latch_r;
endmodule // bit_slice

/* logic/quad_bus_transceiver_reg_latch.sv */
// Quad bus transceiver: muxed driver register onto four inverting three-state
// bus lines, and an inverting transparent receive latch with three-state outputs.
// Assumes every pin input is asynchronous to ref_clk and is synchronised here;
// the wire level of the shared lines is resolved outside from the enables.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module quad_bus_transceiver_reg_latch (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Driver side pins
  input wire logic driver_register_clock,
  input wire logic word_select,
  input wire logic [3:0] first_word_inputs,
  input wire logic [3:0] second_word_inputs,
  input wire logic bus_drive_enable_n,
  // Shared bus lines
  input wire logic [3:0] shared_line_pins_in,
  output logic [3:0] shared_line_pins_out,
  output logic shared_line_pins_oe,
  // Receiver side pins
  input wire logic receive_latch_hold,
  input wire logic receive_output_enable_n,
  output logic [3:0] receiver_outputs,
  output logic receiver_outputs_oe,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [16:0] pins_all;
  logic [16:0] sync1_r;
  logic [16:0] sync1_nxt;
  logic [16:0] sync2_r;
  logic [16:0] sync2_nxt;
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic pin_rise;
  logic sw_capture;
  logic capture;
  logic sel_s;
  logic [3:0] first_s;
  logic [3:0] second_s;
  logic be_n_s;
  logic hold_s;
  logic oe_n_s;
  logic [3:0] bus_s;
  logic [3:0] drv_q;
  logic [3:0] latch_q;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] status_word;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic req;
  logic wr_accept;
  logic count_clr;

  assign pins_all = {driver_register_clock, word_select, first_word_inputs,
                     second_word_inputs, bus_drive_enable_n, receive_latch_hold,
                     receive_output_enable_n, shared_line_pins_in};

  // Two-stage synchroniser for every pin input
  always_comb begin
    sync1_nxt = pins_all;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= xcvr_pkg::SYNC_RST;
      sync2_r <= xcvr_pkg::SYNC_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign sel_s = sync2_r[xcvr_pkg::SY_SEL];
  assign first_s = sync2_r[xcvr_pkg::SY_FIRST_LSB +: 4];
  assign second_s = sync2_r[xcvr_pkg::SY_SECOND_LSB +: 4];
  assign be_n_s = sync2_r[xcvr_pkg::SY_BE_N];
  assign hold_s = sync2_r[xcvr_pkg::SY_HOLD];
  assign oe_n_s = sync2_r[xcvr_pkg::SY_OE_N];
  assign bus_s = sync2_r[xcvr_pkg::SY_BUS_LSB +: 4];

  // Rising edge of the driver register clock, found on the synchronised copy
  always_comb begin
    clk_prev_nxt = sync2_r[xcvr_pkg::SY_CLK];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_r <= xcvr_pkg::CLK_PREV_RST;
    end else begin
      clk_prev_r <= clk_prev_nxt;
    end
  end

  assign pin_rise = sync2_r[xcvr_pkg::SY_CLK] & ~clk_prev_r;
  assign capture = pin_rise | sw_capture;

  // Identical slices, all sharing one set of controls
  genvar gi;
  generate
    for (gi = 0; gi < xcvr_pkg::LANES; gi = gi + 1) begin : g_lane
      bit_slice u_slice (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .first_bit(first_s[gi]),
        .second_bit(second_s[gi]),
        .word_select(sel_s),
        .capture(capture),
        .bus_bit(bus_s[gi]),
        .hold(hold_s),
        .drv_q(drv_q[gi]),
        .latch_q(latch_q[gi])
      );
    end
  endgenerate

  // Pin outputs
  assign shared_line_pins_out = ~drv_q;
  assign shared_line_pins_oe = ~be_n_s;
  assign receiver_outputs = latch_q;
  assign receiver_outputs_oe = ~oe_n_s;

  // Avalon-MM slave: one wait cycle, answer on the second cycle of a request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_accept = avs_write & ack_r;
  assign count_clr = wr_accept && (avs_address == xcvr_pkg::COUNT_OFS);
  assign sw_capture = wr_accept && (avs_address == xcvr_pkg::CTRL_OFS) &&
                      avs_writedata[xcvr_pkg::CTRL_CAPTURE_BIT];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[xcvr_pkg::ST_DRV_LSB +: 4] = drv_q;
    status_word[xcvr_pkg::ST_LATCH_LSB +: 4] = latch_q;
    status_word[xcvr_pkg::ST_BUS_LSB +: 4] = bus_s;
    status_word[xcvr_pkg::ST_DRIVE_ON_BIT] = ~be_n_s;
    status_word[xcvr_pkg::ST_RX_ON_BIT] = ~oe_n_s;
    status_word[xcvr_pkg::ST_SEL_BIT] = sel_s;
    status_word[xcvr_pkg::ST_HOLD_BIT] = hold_s;
  end

  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      if (avs_address == xcvr_pkg::CTRL_OFS) begin
        rdata_nxt = 32'h0000_0000;
      end else if (avs_address == xcvr_pkg::STATUS_OFS) begin
        rdata_nxt = status_word;
      end else if (avs_address == xcvr_pkg::COUNT_OFS) begin
        rdata_nxt = {16'h0000, count_r};
      end else begin
        rdata_nxt = xcvr_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      rdata_r <= xcvr_pkg::READ_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // Capture counter; a capture in the clearing cycle is still counted
  always_comb begin
    count_nxt = count_r;
    if (count_clr) begin
      count_nxt = capture ? 16'h0001 : 16'h0000;
    end else if (capture) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= xcvr_pkg::COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence load_first_s;
    capture && !sel_s;
  endsequence

  sequence load_second_s;
    capture && sel_s;
  endsequence

  sequence be_off_s;
    bus_drive_enable_n [*3];
  endsequence

  sequence be_on_s;
    !bus_drive_enable_n [*3];
  endsequence

  sequence rx_off_s;
    receive_output_enable_n [*3];
  endsequence

  sequence rx_on_s;
    !receive_output_enable_n [*3];
  endsequence

  mux_first_a: assert property (load_first_s |=> drv_q == $past(first_s))
    else $error("first word not loaded");
  mux_second_a: assert property (load_second_s |=> drv_q == $past(second_s))
    else $error("second word not loaded");
  pin_capture_a: assert property (
    $rose(sync2_r[xcvr_pkg::SY_CLK]) |=> drv_q == $past(sel_s ? second_s : first_s))
    else $error("clock edge did not capture");
  reg_steady_a: assert property (!capture |=> $stable(drv_q))
    else $error("driver register changed without edge");
  drive_off_a: assert property (be_off_s |-> !shared_line_pins_oe)
    else $error("bus driven while disabled");
  drive_inverted_a: assert property (
    be_on_s ##0 load_first_s |=> shared_line_pins_oe &&
    shared_line_pins_out == ~$past(first_s))
    else $error("bus level not inverse of stored bit");
  // The arst_n term skips the attempt taken at the release edge, when flops still hold
  latch_follow_a: assert property (
    arst_n && !hold_s |=> latch_q == ~$past(bus_s))
    else $error("open latch did not follow bus");
  latch_hold_a: assert property (hold_s |=> $stable(latch_q))
    else $error("closed latch changed");
  rx_off_a: assert property (rx_off_s |-> !receiver_outputs_oe)
    else $error("receiver outputs driven while disabled");
  rx_on_a: assert property (
    rx_on_s ##0 ($past(arst_n, 2) && !hold_s) |=> receiver_outputs_oe &&
    receiver_outputs == ~$past(bus_s))
    else $error("receiver outputs not showing inverted bus");
  bus_answer_a: assert property (arst_n && avs_waitrequest |=> !avs_waitrequest && req)
    else $error("bus request not answered in one wait cycle");

  // Register bus checks; a request seen at the release edge is skipped
  sequence rd_ctrl_s;
    arst_n && avs_read && !ack_r && (avs_address == xcvr_pkg::CTRL_OFS);
  endsequence

  sequence rd_status_s;
    arst_n && avs_read && !ack_r && (avs_address == xcvr_pkg::STATUS_OFS);
  endsequence

  sequence rd_count_s;
    arst_n && avs_read && !ack_r && (avs_address == xcvr_pkg::COUNT_OFS);
  endsequence

  sequence rd_unmapped_s;
    arst_n && avs_read && !ack_r && (avs_address != xcvr_pkg::CTRL_OFS) &&
    (avs_address != xcvr_pkg::STATUS_OFS) && (avs_address != xcvr_pkg::COUNT_OFS);
  endsequence

  sequence wr_ctrl_go_s;
    wr_accept && (avs_address == xcvr_pkg::CTRL_OFS) &&
    avs_writedata[xcvr_pkg::CTRL_CAPTURE_BIT];
  endsequence

  sw_capture_a: assert property (
    wr_ctrl_go_s ##0 !sel_s |=> drv_q == $past(first_s))
    else $error("software capture did not load register");
  count_clear_a: assert property (count_clr && capture |=> count_r == 16'h0001)
    else $error("capture in clearing cycle lost");
  count_zero_a: assert property (count_clr && !capture |=> count_r == 16'h0000)
    else $error("count not cleared");
  count_step_a: assert property (!count_clr && capture |=> count_r == $past(count_r) + 16'h0001)
    else $error("capture not counted");
  rd_ctrl_a: assert property (rd_ctrl_s |=> avs_readdata == 32'h0000_0000)
    else $error("control register read not zero");
  rd_status_a: assert property (rd_status_s |=> avs_readdata == $past(status_word))
    else $error("status read data wrong");
  rd_count_a: assert property (rd_count_s |=> avs_readdata == {16'h0000, $past(count_r)})
    else $error("count read data wrong");
  rd_unmapped_a: assert property (rd_unmapped_s |=> avs_readdata == xcvr_pkg::UNMAPPED_READ)
    else $error("unmapped read data wrong");
endmodule // quad_bus_transceiver_reg_latch

/* testbench/far_bus_model.sv */
// Far-side model: the shared lines with a second bus driver of the system on them.
// Assumes the device's enable output is high while it drives the lines.
`timescale 1ns/10ps
module far_bus_model (
  // Clock
  input wire logic ref_clk,
  // Device side of the lines
  input wire logic [3:0] dev_out,
  input wire logic dev_oe,
  // Second driver on the shared lines
  input wire logic ext_en,
  input wire logic [3:0] ext_data,
  // Resolved wire level
  output logic [3:0] line
);
  logic [3:0] last_r = 4'h0;
  // Undriven lines float: show a changing pattern, never a held value
  always_comb begin
    if (dev_oe) begin
      line = dev_out;
    end else if (ext_en) begin
      line = ext_data;
    end else begin
      line = ~last_r;
    end
  end
  always_ff @(posedge ref_clk) begin
    last_r <= line;
  end
endmodule // far_bus_model

/* testbench/quad_bus_transceiver_reg_latch_tb.sv */
// Self-checking bench: pin sequences and Avalon-MM register accesses.
// Assumes the far-side model resolves the shared lines from both drivers.
`timescale 1ns/10ps
module quad_bus_transceiver_reg_latch_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic drc = 1'b0;
  logic word_select = 1'b0;
  logic [3:0] first_w = 4'h0;
  logic [3:0] second_w = 4'h0;
  logic be_n = 1'b1;
  logic hold = 1'b0;
  logic rx_oe_n = 1'b1;
  logic ext_en = 1'b0;
  logic [3:0] ext_data = 4'h0;
  logic [3:0] line;
  logic [3:0] line_out;
  logic line_oe;
  logic [3:0] rx_out;
  logic rx_oe;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [3:0] wa[4] = '{4'h5, 4'h0, 4'hC, 4'h9};
  logic [3:0] wb[4] = '{4'hA, 4'h3, 4'hF, 4'h6};
  logic [3:0] exp;
  logic [31:0] rd;

  always #2.5 ref_clk = ~ref_clk;

  quad_bus_transceiver_reg_latch u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .driver_register_clock(drc),
    .word_select(word_select), .first_word_inputs(first_w), .second_word_inputs(second_w),
    .bus_drive_enable_n(be_n), .shared_line_pins_in(line), .shared_line_pins_out(line_out),
    .shared_line_pins_oe(line_oe), .receive_latch_hold(hold),
    .receive_output_enable_n(rx_oe_n), .receiver_outputs(rx_out), .receiver_outputs_oe(rx_oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  far_bus_model u_far (
    .ref_clk(ref_clk), .dev_out(line_out), .dev_oe(line_oe), .ext_en(ext_en),
    .ext_data(ext_data), .line(line)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ends at a falling edge so outputs are settled when looked at
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pulse();
    @(posedge ref_clk);
    drc <= 1'b1;
    repeat (3) @(posedge ref_clk);
    drc <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Waitrequest and read data are taken at the rising edge that ends the transfer
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    idle(4);
    check("line oe idle", 32'(line_oe), 32'h0);
    check("rx oe idle", 32'(rx_oe), 32'h0);
    check("line out reset", 32'(line_out), 32'hF);
    @(posedge ref_clk);
    be_n <= 1'b0;
    rx_oe_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      word_select <= i[0];
      first_w <= wa[i];
      second_w <= wb[i];
      pulse();
      idle(2);
      exp = i[0] ? wb[i] : wa[i];
      check("line out", 32'(line_out), {28'h0, ~exp});
      check("line oe", 32'(line_oe), 32'h1);
      check("rx out", 32'(rx_out), 32'(exp));
      check("rx oe", 32'(rx_oe), 32'h1);
    end
    // Data and select move while the clock stays low
    @(posedge ref_clk);
    word_select <= 1'b0;
    first_w <= 4'hF;
    second_w <= 4'hF;
    idle(6);
    check("line out steady", 32'(line_out), 32'h9);
    bus_read(xcvr_pkg::COUNT_OFS, rd);
    check("count", rd, 32'h4);
    bus_write(xcvr_pkg::COUNT_OFS, 32'h0000_0000);
    bus_read(xcvr_pkg::COUNT_OFS, rd);
    check("count cleared", rd, 32'h0);
    bus_write(xcvr_pkg::CTRL_OFS, 32'h0000_0001);
    idle(3);
    check("line out sw", 32'(line_out), 32'h0);
    bus_read(xcvr_pkg::COUNT_OFS, rd);
    check("count sw", rd, 32'h1);
    // A pin capture that lands in the clearing cycle is still counted
    @(posedge ref_clk);
    drc <= 1'b1;
    bus_write(xcvr_pkg::COUNT_OFS, 32'h0000_0000);
    drc <= 1'b0;
    bus_read(xcvr_pkg::COUNT_OFS, rd);
    check("count set wins", rd, 32'h1);
    // Receive from the second driver
    @(posedge ref_clk);
    be_n <= 1'b1;
    ext_en <= 1'b1;
    ext_data <= 4'h6;
    idle(6);
    check("line oe off", 32'(line_oe), 32'h0);
    check("rx out ext", 32'(rx_out), 32'h9);
    @(posedge ref_clk);
    hold <= 1'b1;
    idle(4);
    @(posedge ref_clk);
    ext_data <= 4'h3;
    idle(6);
    check("rx out held", 32'(rx_out), 32'h9);
    bus_read(xcvr_pkg::STATUS_OFS, rd);
    check("status", rd, 32'h0000_A39F);
    bus_read(xcvr_pkg::CTRL_OFS, rd);
    check("ctrl read", rd, 32'h0);
    bus_read(4'hC, rd);
    check("unmapped", rd, xcvr_pkg::UNMAPPED_READ);
    @(posedge ref_clk);
    rx_oe_n <= 1'b1;
    idle(4);
    check("rx oe off", 32'(rx_oe), 32'h0);
    print_verdict();
  end
endmodule // quad_bus_transceiver_reg_latch_tb
